//--- xbm_pin_mux.sv
// Overview of operation
// - Shared 16/32-bit data, 26-bit address bus.
// - Each chip select spans 64 Mbyte.
// - Static controller drives the selects not assigned to DRAM or flash.
// - Select 1 goes to DRAM or static.
// - Flash support only on select 3.
// - Eight-bit flash data path for ECC controller.
// - Pins steered by current bus owner.
// - Flash enables driven active low.
// - DRAM chip select driven active low.
// - Row and column strobes active low.
// - DRAM address bit ten on own pin.
// - Six devices, each own address space.
// - Assign bit one gives select 1 to DRAM.
// - Assign bit three activates flash logic.
// - Lane bit picks low or high data half.
// - Idle bus holds address and controls stable.
`timescale 1ns/1ps
`include "xbm_params.svh"
module xbm_pin_mux #(
  parameter int DATA_W = `XBM_DATA_W,
  parameter int ADDR_W = `XBM_ADDR_W
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic cs1_assign_bit_in,
  input wire logic cs3_assign_bit_in,
  input wire logic flash_lane_select_in,
  input wire logic wide_bus_in,
  input wire xbm_pkg::xbm_static_t smc_in,
  input wire xbm_pkg::xbm_dram_t dram_in,
  input wire xbm_pkg::xbm_flash_t flash_in,
  input wire logic [31:0] data_pin_in,
  input wire logic external_wait_n_in,
  output logic [5:0] chip_select_n_out,
  output logic read_strobe_n_out,
  output logic write_strobe_n_out,
  output logic [3:0] byte_select_n_out,
  output logic [25:0] addr_out,
  output logic dram_addr_bit_ten_out,
  output logic dram_chip_select_n_out,
  output logic dram_ras_n_out,
  output logic dram_cas_n_out,
  output logic dram_write_n_out,
  output logic dram_clock_enable_out,
  output logic flash_chip_enable_n_out,
  output logic flash_read_enable_n_out,
  output logic flash_write_enable_n_out,
  output logic [31:0] data_pin_out,
  output logic [31:0] data_pin_oe_n_out,
  output logic [31:0] rdata_out,
  output logic [7:0] flash_rdata_out,
  output logic external_wait_n_out,
  output xbm_pkg::xbm_owner_t owner_out
);
  import xbm_pkg::*;

  initial begin
    if (DATA_W != 32 || ADDR_W != 26) begin
      $error("xbm_pin_mux serves only a 32-bit data and 26-bit address layout.");
    end
  end

  xbm_state_t s_q;
  xbm_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.cs1_dram = cs1_assign_bit_in;
    s_d.cs3_flash = cs3_assign_bit_in;
    s_d.lane_hi = flash_lane_select_in;
    s_d.wait_sync = {s_q.wait_sync[0], external_wait_n_in};
    s_d.din_s1 = data_pin_in;
    s_d.din_s2 = s_q.din_s1;
    // flash read lane
    // The lane pick reads the second stage only, so it costs one cycle of latency.
    s_d.fl_rdata = s_q.lane_hi ? s_q.din_s2[23:16] : s_q.din_s2[7:0];
    // owner handover
    // An owner keeps the pins until its busy drops, so float times are respected.
    case (s_q.owner)
      XBM_OWN_IDLE: begin
        if (dram_in.busy && s_q.cs1_dram) begin
          s_d.owner = XBM_OWN_DRAM;
        end else if (flash_in.busy && s_q.cs3_flash) begin
          s_d.owner = XBM_OWN_FLASH;
        end else if (smc_in.busy) begin
          s_d.owner = XBM_OWN_STATIC;
        end
      end
      XBM_OWN_STATIC: begin
        if (!smc_in.busy) begin
          s_d.owner = XBM_OWN_IDLE;
        end
      end
      XBM_OWN_DRAM: begin
        if (!dram_in.busy) begin
          s_d.owner = XBM_OWN_IDLE;
        end
      end
      XBM_OWN_FLASH: begin
        if (!flash_in.busy) begin
          s_d.owner = XBM_OWN_IDLE;
        end
      end
      default: begin
        s_d.owner = XBM_OWN_IDLE;
      end
    endcase
    // idle holds stable
    // Address keeps its last value; strobes and selects return inactive.
    s_d.pins.cs_n = '1;
    s_d.pins.rd_n = 1'b1;
    s_d.pins.we_n = 1'b1;
    s_d.pins.bs_n = '1;
    s_d.pins.dram_cs_n = 1'b1;
    s_d.pins.ras_n = 1'b1;
    s_d.pins.cas_n = 1'b1;
    s_d.pins.sdwe_n = 1'b1;
    s_d.pins.fl_ce_n = 1'b1;
    s_d.pins.fl_re_n = 1'b1;
    s_d.pins.fl_we_n = 1'b1;
    s_d.pins.doe_n = '1;
    // DRAM keeps clock enable level even when it does not own the bus.
    s_d.pins.cke = dram_in.cke;
    case (s_q.owner)
      XBM_OWN_STATIC: begin
        s_d.pins.cs_n = smc_in.cs_n;
        if (s_q.cs1_dram) begin
          s_d.pins.cs_n[`XBM_CS_DRAM] = 1'b1;
        end
        if (s_q.cs3_flash) begin
          s_d.pins.cs_n[`XBM_CS_FLASH] = 1'b1;
        end
        s_d.pins.rd_n = smc_in.rd_n;
        s_d.pins.we_n = smc_in.we_n;
        s_d.pins.bs_n = smc_in.bs_n;
        s_d.pins.addr = smc_in.addr;
        s_d.pins.dout = smc_in.wdata;
        s_d.pins.doe_n = wide_bus_in ? {32{~smc_in.data_oe}}
                                     : {16'hffff, {16{~smc_in.data_oe}}};
      end
      XBM_OWN_DRAM: begin
        s_d.pins.dram_cs_n = dram_in.cs_n;
        s_d.pins.ras_n = dram_in.ras_n;
        s_d.pins.cas_n = dram_in.cas_n;
        s_d.pins.sdwe_n = dram_in.sdwe_n;
        s_d.pins.dram_a10 = dram_in.addr[10];
        s_d.pins.addr[11:2] = dram_in.addr[9:0];
        s_d.pins.addr[15:13] = dram_in.addr[13:11];
        s_d.pins.addr[18:16] = dram_in.ba;
        s_d.pins.bs_n[1] = dram_in.dqm[1];
        s_d.pins.bs_n[2] = dram_in.dqm[2];
        s_d.pins.bs_n[3] = dram_in.dqm[3];
        s_d.pins.dout = dram_in.wdata;
        s_d.pins.doe_n = wide_bus_in ? {32{~dram_in.data_oe}}
                                     : {16'hffff, {16{~dram_in.data_oe}}};
      end
      XBM_OWN_FLASH: begin
        s_d.pins.fl_ce_n = flash_in.ce_n;
        s_d.pins.fl_re_n = flash_in.re_n;
        s_d.pins.fl_we_n = flash_in.we_n;
        s_d.pins.addr[`XBM_ALE_BIT] = flash_in.ale;
        s_d.pins.addr[`XBM_CLE_BIT] = flash_in.cle;
        if (s_q.lane_hi) begin
          s_d.pins.dout[23:16] = flash_in.wdata;
          s_d.pins.doe_n[23:16] = {8{~flash_in.data_oe}};
        end else begin
          s_d.pins.dout[7:0] = flash_in.wdata;
          s_d.pins.doe_n[7:0] = {8{~flash_in.data_oe}};
        end
      end
      default: begin
      end
    endcase
    if (!rst_n_in) begin
      s_d = '0;
      s_d.owner = XBM_OWN_IDLE;
      s_d.cs1_dram = `XBM_RST_CS1_DRAM;
      s_d.cs3_flash = `XBM_RST_CS3_FLASH;
      s_d.lane_hi = `XBM_RST_LANE_HI;
      s_d.wait_sync = 2'b11;
      s_d.pins.cs_n = '1;
      s_d.pins.rd_n = 1'b1;
      s_d.pins.we_n = 1'b1;
      s_d.pins.bs_n = '1;
      s_d.pins.dram_cs_n = 1'b1;
      s_d.pins.ras_n = 1'b1;
      s_d.pins.cas_n = 1'b1;
      s_d.pins.sdwe_n = 1'b1;
      s_d.pins.fl_ce_n = 1'b1;
      s_d.pins.fl_re_n = 1'b1;
      s_d.pins.fl_we_n = 1'b1;
      s_d.pins.doe_n = '1;
    end
  end

  always_ff @(posedge clk_in) begin
    s_q <= s_d;
  end

  assign chip_select_n_out = s_q.pins.cs_n;
  assign read_strobe_n_out = s_q.pins.rd_n;
  assign write_strobe_n_out = s_q.pins.we_n;
  assign byte_select_n_out = s_q.pins.bs_n;
  assign addr_out = s_q.pins.addr;
  assign dram_addr_bit_ten_out = s_q.pins.dram_a10;
  assign dram_chip_select_n_out = s_q.pins.dram_cs_n;
  assign dram_ras_n_out = s_q.pins.ras_n;
  assign dram_cas_n_out = s_q.pins.cas_n;
  assign dram_write_n_out = s_q.pins.sdwe_n;
  assign dram_clock_enable_out = s_q.pins.cke;
  assign flash_chip_enable_n_out = s_q.pins.fl_ce_n;
  assign flash_read_enable_n_out = s_q.pins.fl_re_n;
  assign flash_write_enable_n_out = s_q.pins.fl_we_n;
  assign data_pin_out = s_q.pins.dout;
  assign data_pin_oe_n_out = s_q.pins.doe_n;
  assign rdata_out = s_q.din_s2;
  assign flash_rdata_out = s_q.fl_rdata;
  assign external_wait_n_out = s_q.wait_sync[1];
  assign owner_out = s_q.owner;

  AST_HOLD_OWNER: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s_q.owner == XBM_OWN_DRAM && dram_in.busy) |=> (s_q.owner == XBM_OWN_DRAM))
    else $error("Owner changed while DRAM busy.");
  AST_STATIC_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s_q.owner == XBM_OWN_STATIC && smc_in.busy) |=> (s_q.owner == XBM_OWN_STATIC))
    else $error("Owner changed while static busy.");
  AST_CS1_BLOCK: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    s_q.cs1_dram |=> chip_select_n_out[1])
    else $error("Select 1 driven by static while assigned to DRAM.");
  AST_DRAM_CS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s_q.owner != XBM_OWN_DRAM) |=> dram_chip_select_n_out && dram_ras_n_out)
    else $error("DRAM strobes active without ownership.");
  AST_FLASH_CE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !flash_chip_enable_n_out |-> $past(s_q.owner) == XBM_OWN_FLASH && $past(flash_in.ce_n) == 1'b0)
    else $error("Flash enable active without cause.");
  sequence xbm_idle_twice;
    (s_q.owner == XBM_OWN_IDLE) ##1 (s_q.owner == XBM_OWN_IDLE);
  endsequence
  AST_IDLE_ADDR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    xbm_idle_twice |=> $stable(addr_out))
    else $error("Address moved while idle.");
  AST_A10: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s_q.owner == XBM_OWN_STATIC) |=> $stable(dram_addr_bit_ten_out))
    else $error("Static access moved DRAM bit ten.");
  AST_LANE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (s_q.owner == XBM_OWN_FLASH && s_q.lane_hi) |=> (&data_pin_oe_n_out[7:0]))
    else $error("Low lane driven while high lane chosen.");
endmodule // xbm_pin_mux

//--- xbm_params.svh
`ifndef XBM_PARAMS_SVH
`define XBM_PARAMS_SVH
`define XBM_DATA_W 32
`define XBM_ADDR_W 26
`define XBM_NCS 6
`define XBM_DRAM_ADDR_W 14
`define XBM_CS_DRAM 1
`define XBM_CS_FLASH 3
`define XBM_RST_CS1_DRAM 1'b0
`define XBM_RST_CS3_FLASH 1'b0
`define XBM_RST_LANE_HI 1'b0
`define XBM_ALE_BIT 21
`define XBM_CLE_BIT 22
`endif

//--- xbm_pkg.sv
package xbm_pkg;
  typedef enum logic [1:0] {
    XBM_OWN_IDLE = 2'b00,
    XBM_OWN_STATIC = 2'b01,
    XBM_OWN_DRAM = 2'b10,
    XBM_OWN_FLASH = 2'b11
  } xbm_owner_t;

  typedef struct packed {
    logic [5:0] cs_n;
    logic rd_n;
    logic we_n;
    logic [3:0] bs_n;
    logic [25:0] addr;
    logic [31:0] wdata;
    logic data_oe;
    logic busy;
  } xbm_static_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic sdwe_n;
    logic cke;
    logic [13:0] addr;
    logic [2:0] ba;
    logic [3:0] dqm;
    logic [31:0] wdata;
    logic data_oe;
    logic busy;
  } xbm_dram_t;

  typedef struct packed {
    logic ce_n;
    logic re_n;
    logic we_n;
    logic ale;
    logic cle;
    logic [7:0] wdata;
    logic data_oe;
    logic busy;
  } xbm_flash_t;

  typedef struct packed {
    logic [5:0] cs_n;
    logic rd_n;
    logic we_n;
    logic [3:0] bs_n;
    logic [25:0] addr;
    logic dram_a10;
    logic dram_cs_n;
    logic ras_n;
    logic cas_n;
    logic sdwe_n;
    logic cke;
    logic fl_ce_n;
    logic fl_re_n;
    logic fl_we_n;
    logic [31:0] dout;
    logic [31:0] doe_n;
  } xbm_pins_t;

  typedef struct packed {
    xbm_owner_t owner;
    logic cs1_dram;
    logic cs3_flash;
    logic lane_hi;
    logic [1:0] wait_sync;
    logic [31:0] din_s1;
    logic [31:0] din_s2;
    logic [7:0] fl_rdata;
    xbm_pins_t pins;
  } xbm_state_t;
endpackage

//--- xbm_mem_model.sv
`timescale 1ns/1ps
module xbm_mem_model (
  input wire logic clk_in,
  input wire logic slow_in,
  input wire logic [5:0] cs_n_in,
  input wire logic rd_n_in,
  input wire logic [25:0] addr_in,
  input wire logic [31:0] dout_in,
  input wire logic [31:0] oe_n_in,
  output logic [31:0] data_out,
  output logic wait_n_out
);
  logic [31:0] float_q = 32'h5555_5555;
  logic [31:0] word;
  logic reading;
  // A released line has no keeper here, so it flips every cycle.
  always_ff @(posedge clk_in) begin
    float_q <= ~float_q;
  end
  assign reading = (cs_n_in != 6'h3f) && !rd_n_in;
  assign word = {6'h00, addr_in} ^ 32'hc000_0000;
  // A slow device stretches every read with the wait line.
  assign wait_n_out = !(slow_in && reading);
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      data_out[i] = !oe_n_in[i] ? dout_in[i] : (reading ? word[i] : float_q[i]);
    end
  end
endmodule // xbm_mem_model

//--- external_memory_pin_mux_tb_top.sv
`timescale 1ns/1ps
module external_memory_pin_mux_tb_top;
  import xbm_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cs1, cs3, lane, wide, slow, wait_n, rd_n, we_n, a10, dcs_n, ras_n, cas_n;
  logic dwe_n, cke, fce_n, fre_n, fwe_n, wait_o;
  xbm_static_t static_mem_ctrl, s;
  xbm_dram_t dram, d;
  xbm_flash_t flash, f;
  logic [31:0] din, dout, oe_n, rdata;
  logic [25:0] addr;
  logic [5:0] cs_n;
  logic [3:0] bs_n;
  logic [7:0] frd;
  xbm_owner_t owner;
  int errors = 0;
  int compares = 0;
  logic [31:0] exp_q[$];

  always #5 clk_in = ~clk_in;

  xbm_pin_mux dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .cs1_assign_bit_in(cs1),
    .cs3_assign_bit_in(cs3), .flash_lane_select_in(lane), .wide_bus_in(wide),
    .smc_in(static_mem_ctrl), .dram_in(dram), .flash_in(flash), .data_pin_in(din),
    .external_wait_n_in(wait_n), .chip_select_n_out(cs_n), .read_strobe_n_out(rd_n),
    .write_strobe_n_out(we_n), .byte_select_n_out(bs_n), .addr_out(addr),
    .dram_addr_bit_ten_out(a10), .dram_chip_select_n_out(dcs_n), .dram_ras_n_out(ras_n),
    .dram_cas_n_out(cas_n), .dram_write_n_out(dwe_n), .dram_clock_enable_out(cke),
    .flash_chip_enable_n_out(fce_n), .flash_read_enable_n_out(fre_n),
    .flash_write_enable_n_out(fwe_n), .data_pin_out(dout), .data_pin_oe_n_out(oe_n),
    .rdata_out(rdata), .flash_rdata_out(frd), .external_wait_n_out(wait_o),
    .owner_out(owner));

  xbm_mem_model mem (.clk_in(clk_in), .slow_in(slow), .cs_n_in(cs_n), .rd_n_in(rd_n),
    .addr_in(addr), .dout_in(dout), .oe_n_in(oe_n), .data_out(din), .wait_n_out(wait_n));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #100000;
    errors++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'h8803));
    static_mem_ctrl = '1;
    static_mem_ctrl.busy = 1'b0;
    dram = '1;
    dram.busy = 1'b0;
    flash = '1;
    flash.busy = 1'b0;
    {cs1, cs3, lane, wide, slow} = 5'b00010;
    tick(3);
    rst_n_in <= 1'b1;
    #1;
    chk("owner", XBM_OWN_IDLE, owner);
    chk("controls", 32'h7f, {dcs_n, ras_n, cas_n, fce_n, fre_n, fwe_n, rd_n});
    chk("oe", 32'hffff_ffff, oe_n);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      tick(1);
      cs1 <= k[0];
      wide <= k[1];
      s = '1;
      s.cs_n = 6'($urandom());
      s.we_n = 1'b0;
      s.bs_n = 4'($urandom());
      s.addr = 26'($urandom());
      s.wdata = $urandom();
      tick(1);
      static_mem_ctrl <= s;
      tick(1);
      #1;
      chk("owner", XBM_OWN_STATIC, owner);
      tick(1);
      #1;
      chk("selects", k[0] ? s.cs_n | 6'h02 : s.cs_n, cs_n);
      chk("addr", s.addr, addr);
      chk("strobes", {s.bs_n, 2'b10}, {bs_n, rd_n, we_n});
      chk("oe", k[1] ? 32'h0 : 32'hffff_0000, oe_n);
      chk("data", k[1] ? s.wdata : {16'h0000, s.wdata[15:0]},
        k[1] ? dout : {16'h0000, dout[15:0]});
      tick(1);
      static_mem_ctrl.busy <= 1'b0;
      tick(3);
      #1;
      chk("idle", {6'h3f, s.addr}, {cs_n, addr});
    end
    $display("test static write done");
    for (int k = 0; k < 2; k++) begin
      tick(1);
      slow <= k[0];
      cs1 <= 1'b0;
      s = '1;
      s.cs_n = 6'h3e;
      s.rd_n = 1'b0;
      s.addr = 26'($urandom());
      s.data_oe = 1'b0;
      exp_q.push_back({6'h00, s.addr} ^ 32'hc000_0000);
      tick(1);
      static_mem_ctrl <= s;
      tick(5);
      #1;
      chk("read data", exp_q.pop_front(), rdata);
      chk("wait", k[0] ? 32'h0 : 32'h1, wait_o);
      tick(1);
      static_mem_ctrl.busy <= 1'b0;
      tick(2);
    end
    $display("test static read done");
    d = '1;
    {d.cs_n, d.ras_n, d.data_oe} = 3'b000;
    d.addr = 14'($urandom());
    d.ba = 3'($urandom());
    d.dqm = 4'($urandom());
    tick(1);
    dram <= d;
    tick(3);
    #1;
    chk("dram refused", {XBM_OWN_IDLE, 6'h3f}, {owner, cs_n});
    tick(1);
    cs1 <= 1'b1;
    tick(4);
    #1;
    chk("owner", XBM_OWN_DRAM, owner);
    chk("bit ten", d.addr[10], a10);
    chk("dram addr", {d.ba, d.addr[13:11], d.addr[9:0]}, {addr[18:13], addr[11:2]});
    chk("dram strobes", 5'b00111, {dcs_n, ras_n, cas_n, dwe_n, cke});
    chk("dram mask", d.dqm[3:1], bs_n[3:1]);
    tick(1);
    dram.busy <= 1'b0;
    $display("test dram done");
    for (int k = 0; k < 3; k++) begin
      tick(2);
      cs3 <= (k != 0);
      lane <= (k == 2);
      f = '1;
      {f.ce_n, f.we_n, f.cle} = 3'b000;
      f.wdata = 8'($urandom());
      tick(1);
      flash <= f;
      tick(4);
      #1;
      chk("owner", k == 0 ? XBM_OWN_IDLE : XBM_OWN_FLASH, owner);
      if (k != 0) begin
        chk("flash strobes", 3'b010, {fce_n, fre_n, fwe_n});
        chk("latch", 2'b01, {addr[22], addr[21]});
        chk("lane", {f.wdata, 8'h00}, k == 2 ? {dout[23:16], oe_n[23:16]} :
          {dout[7:0], oe_n[7:0]});
      end
      tick(1);
      flash.busy <= 1'b0;
      #1;
      if (k != 0) begin
        chk("flash read", f.wdata, frd);
      end
    end
    $display("test flash done");
    report_and_stop();
  end
endmodule // external_memory_pin_mux_tb_top
